// ===== common/sic_defs.vh
// constants of the six-source interrupt control unit
`ifndef SIC_DEFS_VH
`define SIC_DEFS_VH

// nibble addresses of the control bits
`define SIC_ADDR_W          10
`define SIC_ADDR_CTRL0      10'h000
`define SIC_ADDR_CTRL1      10'h001
`define SIC_ADDR_CTRL2      10'h002
`define SIC_ADDR_CTRL3      10'h003
`define SIC_ADDR_PORTSEL    10'h004

// bit positions inside each nibble
`define SIC_B0_GIE          0
`define SIC_B0_EXT0_PEND    2
`define SIC_B0_EXT0_MASK    3
`define SIC_B1_EXT1_PEND    0
`define SIC_B1_EXT1_MASK    1
`define SIC_B1_TMRA_PEND    2
`define SIC_B1_TMRA_MASK    3
`define SIC_B2_TMRB_PEND    0
`define SIC_B2_TMRB_MASK    1
`define SIC_B2_TMRC_PEND    2
`define SIC_B2_TMRC_MASK    3
`define SIC_B3_SER_PEND     0
`define SIC_B3_SER_MASK     1
`define SIC_PS_EXT0_SEL     0
`define SIC_PS_EXT1_SEL     1

// reset values
`define SIC_RST_GIE         1'h0
`define SIC_RST_PEND        6'h00
`define SIC_RST_MASK        6'h3F
`define SIC_RST_PORTSEL     4'h0
`define SIC_RST_NIBBLE      4'h0

// source indices, highest priority first
`define SIC_SRC_N           6
`define SIC_SRC_EXT0        0
`define SIC_SRC_EXT1        1
`define SIC_SRC_TMRA        2
`define SIC_SRC_TMRB        3
`define SIC_SRC_TMRC        4
`define SIC_SRC_SER         5

// vector addresses
`define SIC_PC_W            14
`define SIC_VEC_RESET       14'h0000
`define SIC_VEC_EXT0        14'h0002
`define SIC_VEC_EXT1        14'h0004
`define SIC_VEC_TMRA        14'h0006
`define SIC_VEC_TMRB        14'h0008
`define SIC_VEC_TMRC        14'h000A
`define SIC_VEC_SER         14'h000C

// stack pointer
`define SIC_SP_W            10
`define SIC_SP_RESET        10'h3FF
`define SIC_SP_STEP         10'h004

// external edge filter: level must hold more than two instruction cycles
`define SIC_EDGE_HOLD       3

`endif

// ===== logic/sic_edge_filter.v
// synchroniser and held-level falling edge detector for one pin
`timescale 1ns/100ps
`default_nettype none

module sic_edge_filter #(
	parameter HOLD = 3,
	parameter CW   = 2
) (
	input  wire          SYS_CLK,
	input  wire          RESET,
	input  wire          PIN_N,
	input  wire          CYC_EN,
	output reg           FALL
);

	reg          sync1_q;
	reg          sync2_q;
	reg          level_q;
	reg [CW-1:0] run_q;

	////////////////////////////////////////////////////////////////////////
	// two flip-flops ahead of any logic
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			sync1_q <= 1'b1;
			sync2_q <= 1'b1;
		end else begin
			sync1_q <= PIN_N;
			sync2_q <= sync1_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// level flips only after HOLD differing samples, one per cycle enable
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			level_q <= 1'b1;
			run_q   <= {CW{1'b0}};
			FALL    <= 1'b0;
		end else begin
			FALL <= 1'b0;
			if (CYC_EN) begin
				if (sync2_q != level_q) begin
					if (run_q == HOLD[CW-1:0] - 1'b1) begin
						level_q <= sync2_q;
						run_q   <= {CW{1'b0}};
						FALL    <= ~sync2_q;
					end else begin
						run_q <= run_q + 1'b1;
					end
				end else begin
					run_q <= {CW{1'b0}};
				end
			end
		end
	end

endmodule

`default_nettype wire

// ===== logic/sic_irq_ctrl.v
// six-source interrupt control unit with nibble-mapped control bits
// Notes on behaviour
// - six sources, each with its own pending flag, mask bit and vector.
// - all enable, pending and mask bits live at nibble addresses 0 to 3.
// - software writes can only clear pending flags, never set them.
// - reset clears global enable and pending flags, sets every mask.
// - request needs pending one and mask zero; service needs enable one.
// - fixed priority ext0 to serial, vectors 2,4,6,8,A,C; reset uses 0.
// - instruction completes in entry cycle one; enable cleared in cycle two.
// - carry, status and program counter pushed in cycles two and three.
// - cycle three loads the program counter with the chosen vector.
// - accepting an interrupt leaves the pending flag set.
// - enable cleared on entry, set again by the return-from-interrupt.
// - external pending flags set on falling edge of their active-low pins.
// - port function select at nibble 4 chooses pins as request inputs.
// - ext1 pin can clock timer B on each falling edge.
// - edges count only after the level holds over two instruction cycles.
// - timer A, B, C pending flags set by their overflow outputs.
// - serial flag set after eight transfer clocks or on transfer abort.
// - stack pointer drops by four per push, rises by four per restore.
`timescale 1ns/100ps
`default_nettype none
`include "sic_defs.vh"

module sic_irq_ctrl #(
	parameter EDGE_HOLD = `SIC_EDGE_HOLD
) (
	input  wire                   SYS_CLK,
	input  wire                   RESET,
	input  wire                   CYC_EN,
	input  wire                   EXT0_PIN_N,
	input  wire                   EXT1_PIN_N,
	input  wire                   TMRA_OVF,
	input  wire                   TMRB_OVF,
	input  wire                   TMRC_OVF,
	input  wire                   SER_DONE,
	input  wire                   SER_ABORT,
	input  wire                   RETURN_FROM_IRQ_INSTR_EXEC,
	input  wire                   MEM_RD,
	input  wire                   MEM_WE,
	input  wire [`SIC_ADDR_W-1:0] MEM_ADDR,
	input  wire [3:0]             MEM_BEN,
	input  wire [3:0]             MEM_WDATA,
	input  wire [1:0]             CARRY_STATUS,
	input  wire [`SIC_PC_W-1:0]   PC_RETURN,
	output reg  [3:0]             MEM_RDATA,
	output reg                    MEM_HIT,
	output reg                    GLOBAL_IE,
	output reg                    IRQ_REQUEST,
	output reg                    ENTRY_FINISH,
	output reg                    ENTRY_PUSH_HI,
	output reg                    ENTRY_JUMP,
	output reg  [`SIC_PC_W-1:0]   PC_VECTOR,
	output reg  [`SIC_SP_W-1:0]   STACK_PTR,
	output reg  [15:0]            PUSH_DATA,
	output reg                    TMRB_EVENT
);

	////////////////////////////////////////////////////////////////////////
	// functions

	// merge write data into a nibble under the bit enables
	function [3:0] nib_merge;
		input [3:0] old_v;
		input [3:0] wdata;
		input [3:0] ben;
		begin
			nib_merge = (old_v & ~ben) | (wdata & ben);
		end
	endfunction

	// fixed-priority vector of the highest requesting source
	function [`SIC_PC_W-1:0] prio_vec;
		input [`SIC_SRC_N-1:0] req;
		begin
			if (req[`SIC_SRC_EXT0])
				prio_vec = `SIC_VEC_EXT0;
			else if (req[`SIC_SRC_EXT1])
				prio_vec = `SIC_VEC_EXT1;
			else if (req[`SIC_SRC_TMRA])
				prio_vec = `SIC_VEC_TMRA;
			else if (req[`SIC_SRC_TMRB])
				prio_vec = `SIC_VEC_TMRB;
			else if (req[`SIC_SRC_TMRC])
				prio_vec = `SIC_VEC_TMRC;
			else if (req[`SIC_SRC_SER])
				prio_vec = `SIC_VEC_SER;
			else
				prio_vec = `SIC_VEC_RESET;
		end
	endfunction

	////////////////////////////////////////////////////////////////////////
	// declarations

	localparam [3:0] ST_IDLE = 4'h1;
	localparam [3:0] ST_ENT1 = 4'h2;
	localparam [3:0] ST_ENT2 = 4'h4;
	localparam [3:0] ST_ENT3 = 4'h8;

	reg  [3:0]             state_q;
	reg  [3:0]             state_d;
	reg  [`SIC_SRC_N-1:0]  pend_q;
	reg  [`SIC_SRC_N-1:0]  pend_d;
	reg  [`SIC_SRC_N-1:0]  mask_q;
	reg  [`SIC_SRC_N-1:0]  mask_d;
	reg                    gie_d;
	reg  [3:0]             psel_q;
	reg  [`SIC_PC_W-1:0]   vec_d;
	reg  [`SIC_SP_W-1:0]   sp_d;
	reg  [3:0]             rd_nib;
	reg  [3:0]             cur0;
	reg  [3:0]             cur1;
	reg  [3:0]             cur2;
	reg  [3:0]             cur3;
	reg  [3:0]             new0;
	reg  [3:0]             new1;
	reg  [3:0]             new2;
	reg  [3:0]             new3;

	wire                   ext0_fall;
	wire                   ext1_fall;
	wire [`SIC_SRC_N-1:0]  hw_set;
	wire [`SIC_SRC_N-1:0]  active_req;
	wire                   wr0;
	wire                   wr1;
	wire                   wr2;
	wire                   wr3;
	wire                   wr4;
	wire                   accept;

	////////////////////////////////////////////////////////////////////////
	// external pin edge filters

	sic_edge_filter #(
		.HOLD (EDGE_HOLD),
		.CW   (2)
	) u_ext0 (
		.SYS_CLK (SYS_CLK),
		.RESET   (RESET),
		.PIN_N   (EXT0_PIN_N),
		.CYC_EN  (CYC_EN),
		.FALL    (ext0_fall)
	);

	sic_edge_filter #(
		.HOLD (EDGE_HOLD),
		.CW   (2)
	) u_ext1 (
		.SYS_CLK (SYS_CLK),
		.RESET   (RESET),
		.PIN_N   (EXT1_PIN_N),
		.CYC_EN  (CYC_EN),
		.FALL    (ext1_fall)
	);

	////////////////////////////////////////////////////////////////////////
	// hardware set events and request qualification

	assign hw_set[`SIC_SRC_EXT0] = ext0_fall &
		psel_q[`SIC_PS_EXT0_SEL];
	assign hw_set[`SIC_SRC_EXT1] = ext1_fall &
		psel_q[`SIC_PS_EXT1_SEL];
	assign hw_set[`SIC_SRC_TMRA] = TMRA_OVF;
	assign hw_set[`SIC_SRC_TMRB] = TMRB_OVF;
	assign hw_set[`SIC_SRC_TMRC] = TMRC_OVF;
	assign hw_set[`SIC_SRC_SER]  = SER_DONE | SER_ABORT;

	assign active_req = pend_q & ~mask_q;
	assign accept     = (state_q == ST_IDLE) & CYC_EN &
		GLOBAL_IE & (|active_req);

	////////////////////////////////////////////////////////////////////////
	// nibble access decode

	assign wr0 = MEM_WE & (MEM_ADDR == `SIC_ADDR_CTRL0);
	assign wr1 = MEM_WE & (MEM_ADDR == `SIC_ADDR_CTRL1);
	assign wr2 = MEM_WE & (MEM_ADDR == `SIC_ADDR_CTRL2);
	assign wr3 = MEM_WE & (MEM_ADDR == `SIC_ADDR_CTRL3);
	assign wr4 = MEM_WE & (MEM_ADDR == `SIC_ADDR_PORTSEL);

	// current nibble images of the control bits
	always @* begin
		cur0 = `SIC_RST_NIBBLE;
		cur1 = `SIC_RST_NIBBLE;
		cur2 = `SIC_RST_NIBBLE;
		cur3 = `SIC_RST_NIBBLE;
		cur0[`SIC_B0_GIE]       = GLOBAL_IE;
		cur0[`SIC_B0_EXT0_PEND] = pend_q[`SIC_SRC_EXT0];
		cur0[`SIC_B0_EXT0_MASK] = mask_q[`SIC_SRC_EXT0];
		cur1[`SIC_B1_EXT1_PEND] = pend_q[`SIC_SRC_EXT1];
		cur1[`SIC_B1_EXT1_MASK] = mask_q[`SIC_SRC_EXT1];
		cur1[`SIC_B1_TMRA_PEND] = pend_q[`SIC_SRC_TMRA];
		cur1[`SIC_B1_TMRA_MASK] = mask_q[`SIC_SRC_TMRA];
		cur2[`SIC_B2_TMRB_PEND] = pend_q[`SIC_SRC_TMRB];
		cur2[`SIC_B2_TMRB_MASK] = mask_q[`SIC_SRC_TMRB];
		cur2[`SIC_B2_TMRC_PEND] = pend_q[`SIC_SRC_TMRC];
		cur2[`SIC_B2_TMRC_MASK] = mask_q[`SIC_SRC_TMRC];
		cur3[`SIC_B3_SER_PEND]  = pend_q[`SIC_SRC_SER];
		cur3[`SIC_B3_SER_MASK]  = mask_q[`SIC_SRC_SER];
		new0 = nib_merge(cur0, MEM_WDATA, MEM_BEN);
		new1 = nib_merge(cur1, MEM_WDATA, MEM_BEN);
		new2 = nib_merge(cur2, MEM_WDATA, MEM_BEN);
		new3 = nib_merge(cur3, MEM_WDATA, MEM_BEN);
	end

	////////////////////////////////////////////////////////////////////////
	// next values of pending flags, masks and global enable

	always @* begin
		pend_d = pend_q;
		mask_d = mask_q;
		gie_d  = GLOBAL_IE;
		// software may only clear a pending flag: and, never or
		if (wr0) begin
			gie_d = new0[`SIC_B0_GIE];
			pend_d[`SIC_SRC_EXT0] = pend_q[`SIC_SRC_EXT0] &
				new0[`SIC_B0_EXT0_PEND];
			mask_d[`SIC_SRC_EXT0] = new0[`SIC_B0_EXT0_MASK];
		end
		if (wr1) begin
			pend_d[`SIC_SRC_EXT1] = pend_q[`SIC_SRC_EXT1] &
				new1[`SIC_B1_EXT1_PEND];
			mask_d[`SIC_SRC_EXT1] = new1[`SIC_B1_EXT1_MASK];
			pend_d[`SIC_SRC_TMRA] = pend_q[`SIC_SRC_TMRA] &
				new1[`SIC_B1_TMRA_PEND];
			mask_d[`SIC_SRC_TMRA] = new1[`SIC_B1_TMRA_MASK];
		end
		if (wr2) begin
			pend_d[`SIC_SRC_TMRB] = pend_q[`SIC_SRC_TMRB] &
				new2[`SIC_B2_TMRB_PEND];
			mask_d[`SIC_SRC_TMRB] = new2[`SIC_B2_TMRB_MASK];
			pend_d[`SIC_SRC_TMRC] = pend_q[`SIC_SRC_TMRC] &
				new2[`SIC_B2_TMRC_PEND];
			mask_d[`SIC_SRC_TMRC] = new2[`SIC_B2_TMRC_MASK];
		end
		if (wr3) begin
			pend_d[`SIC_SRC_SER] = pend_q[`SIC_SRC_SER] &
				new3[`SIC_B3_SER_PEND];
			mask_d[`SIC_SRC_SER] = new3[`SIC_B3_SER_MASK];
		end
		// hardware set applied last so it wins over a clear
		pend_d = pend_d | hw_set;
		// the return instruction re-enables, entry cycle two disables
		if (RETURN_FROM_IRQ_INSTR_EXEC)
			gie_d = 1'b1;
		if ((state_q == ST_ENT1) && CYC_EN)
			gie_d = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// entry sequencer, one state per instruction cycle

	always @* begin
		state_d = state_q;
		vec_d   = PC_VECTOR;
		sp_d    = STACK_PTR;
		case (state_q)
		ST_IDLE: begin
			if (accept) begin
				state_d = ST_ENT1;
				vec_d   = prio_vec(active_req);
			end
			if (RETURN_FROM_IRQ_INSTR_EXEC)
				sp_d = STACK_PTR + `SIC_SP_STEP;
		end
		ST_ENT1: begin
			if (CYC_EN)
				state_d = ST_ENT2;
		end
		ST_ENT2: begin
			if (CYC_EN)
				state_d = ST_ENT3;
		end
		ST_ENT3: begin
			if (CYC_EN) begin
				state_d = ST_IDLE;
				sp_d    = STACK_PTR - `SIC_SP_STEP;
			end
		end
		default: begin
			state_d = ST_IDLE;
		end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// read data path

	always @* begin
		case (MEM_ADDR)
		`SIC_ADDR_CTRL0:   rd_nib = cur0;
		`SIC_ADDR_CTRL1:   rd_nib = cur1;
		`SIC_ADDR_CTRL2:   rd_nib = cur2;
		`SIC_ADDR_CTRL3:   rd_nib = cur3;
		`SIC_ADDR_PORTSEL: rd_nib = psel_q;
		default:           rd_nib = `SIC_RST_NIBBLE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// registers

	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			pend_q    <= `SIC_RST_PEND;
			mask_q    <= `SIC_RST_MASK;
			GLOBAL_IE <= `SIC_RST_GIE;
			psel_q    <= `SIC_RST_PORTSEL;
			state_q   <= ST_IDLE;
			PC_VECTOR <= `SIC_VEC_RESET;
			STACK_PTR <= `SIC_SP_RESET;
		end else begin
			// acceptance never touches the flags
			pend_q    <= pend_d;
			mask_q    <= mask_d;
			GLOBAL_IE <= gie_d;
			state_q   <= state_d;
			PC_VECTOR <= vec_d;
			STACK_PTR <= sp_d;
			if (wr4)
				psel_q <= nib_merge(psel_q, MEM_WDATA, MEM_BEN);
		end
	end

	// registered outputs toward the core
	always @(posedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			MEM_RDATA     <= `SIC_RST_NIBBLE;
			MEM_HIT       <= 1'b0;
			IRQ_REQUEST   <= 1'b0;
			ENTRY_FINISH  <= 1'b0;
			ENTRY_PUSH_HI <= 1'b0;
			ENTRY_JUMP    <= 1'b0;
			PUSH_DATA     <= 16'h0000;
			TMRB_EVENT    <= 1'b0;
		end else begin
			MEM_HIT       <= MEM_RD &
				(MEM_ADDR <= `SIC_ADDR_PORTSEL);
			if (MEM_RD)
				MEM_RDATA <= rd_nib;
			IRQ_REQUEST   <= |active_req;
			ENTRY_FINISH  <= state_d == ST_ENT1;
			ENTRY_PUSH_HI <= (state_d == ST_ENT2) |
				(state_d == ST_ENT3);
			ENTRY_JUMP    <= state_d == ST_ENT3;
			if (accept)
				PUSH_DATA <= {CARRY_STATUS, PC_RETURN};
			TMRB_EVENT    <= ext1_fall &
				~psel_q[`SIC_PS_EXT1_SEL];
		end
	end

endmodule

`default_nettype wire

// ===== test/sic_irq_chk_asserts.sv
// concurrent checks on the ports of the interrupt control unit
`timescale 1ns/100ps
`default_nettype none

module sic_irq_chk (
	input wire        SYS_CLK,
	input wire        RESET,
	input wire        CYC_EN,
	input wire        RETURN_FROM_IRQ_INSTR_EXEC,
	input wire        MEM_RD,
	input wire [9:0]  MEM_ADDR,
	input wire [1:0]  CARRY_STATUS,
	input wire [13:0] PC_RETURN,
	input wire [3:0]  MEM_RDATA,
	input wire        MEM_HIT,
	input wire        GLOBAL_IE,
	input wire        ENTRY_FINISH,
	input wire        ENTRY_PUSH_HI,
	input wire        ENTRY_JUMP,
	input wire [13:0] PC_VECTOR,
	input wire [9:0]  STACK_PTR,
	input wire [15:0] PUSH_DATA
);
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (RESET);
	////////////////
	// entry steps
	sequence s_c1; ENTRY_FINISH && CYC_EN; endsequence
	sequence s_c2; !GLOBAL_IE && ENTRY_PUSH_HI && !ENTRY_FINISH; endsequence
	sequence s_c3; ENTRY_PUSH_HI && !ENTRY_JUMP && CYC_EN; endsequence
	sequence s_c4; ENTRY_JUMP && ENTRY_PUSH_HI && !GLOBAL_IE; endsequence
	property p_acc; $rose(ENTRY_FINISH) |-> $past(CYC_EN) && $past(GLOBAL_IE);
	endproperty
	property p_ie; s_c1 |=> s_c2; endproperty
	property p_jmp; s_c3 |=> s_c4; endproperty
	property p_sp; ENTRY_JUMP && CYC_EN |=> !ENTRY_PUSH_HI && !ENTRY_JUMP
		&& STACK_PTR == $past(STACK_PTR) - 10'h004; endproperty
	property p_ret; RETURN_FROM_IRQ_INSTR_EXEC && !ENTRY_FINISH && !ENTRY_PUSH_HI |=>
		GLOBAL_IE && STACK_PTR == $past(STACK_PTR) + 10'h004; endproperty
	property p_vec; $rose(ENTRY_FINISH) |-> !PC_VECTOR[0]
		&& PC_VECTOR inside {[14'h0002:14'h000C]}; endproperty
	property p_hold; ENTRY_PUSH_HI |-> $stable(PC_VECTOR)
		&& $stable(PUSH_DATA); endproperty
	property p_push; $rose(ENTRY_FINISH) |->
		PUSH_DATA == {$past(CARRY_STATUS), $past(PC_RETURN)}; endproperty
	property p_hit; MEM_RD |=> MEM_HIT == ($past(MEM_ADDR) <= 10'h004);
	endproperty
	property p_rd0; MEM_RD && MEM_ADDR > 10'h004 |=> MEM_RDATA == 4'h0;
	endproperty
	a_acc: assert property (p_acc) else $error("entry without enable");
	a_ie: assert property (p_ie) else $error("enable not cleared");
	a_jmp: assert property (p_jmp) else $error("no jump cycle");
	a_sp: assert property (p_sp) else $error("push step wrong");
	a_ret: assert property (p_ret) else $error("return wrong");
	a_vec: assert property (p_vec) else $error("bad vector");
	a_hold: assert property (p_hold) else $error("entry data moved");
	a_push: assert property (p_push) else $error("push data wrong");
	a_hit: assert property (p_hit) else $error("hit flag wrong");
	a_rd0: assert property (p_rd0) else $error("unmapped read");
endmodule

bind sic_irq_ctrl sic_irq_chk sic_irq_chk_inst (.SYS_CLK, .RESET,
	.CYC_EN, .RETURN_FROM_IRQ_INSTR_EXEC, .MEM_RD, .MEM_ADDR, .CARRY_STATUS, .PC_RETURN,
	.MEM_RDATA, .MEM_HIT, .GLOBAL_IE, .ENTRY_FINISH, .ENTRY_PUSH_HI,
	.ENTRY_JUMP, .PC_VECTOR, .STACK_PTR, .PUSH_DATA);
`default_nettype wire

// ===== test/sic_core_model.sv
// core sequencer model: cycle enables, running pc, return pulses
`timescale 1ns/100ps
`default_nettype none

module sic_core_model (
	input  wire         SYS_CLK,
	input  wire         RESET,
	input  wire         slow,
	input  wire         return_from_irq_instr_go,
	input  wire         entry_jump,
	input  wire [13:0]  pc_vector,
	output logic        cyc_en,
	output logic        return_from_irq_instr_exec,
	output logic [1:0]  carry_status,
	output logic [13:0] pc_q
);
	logic [1:0] div_q;

	// moves on the falling edge, clear of the sampling edge
	always @(negedge SYS_CLK or posedge RESET) begin
		if (RESET) begin
			div_q <= 2'h0;
			cyc_en <= 1'b0;
			return_from_irq_instr_exec <= 1'b0;
			pc_q <= 14'h0000;
		end else begin
			div_q <= div_q + 2'h1;
			cyc_en <= !slow || div_q == 2'h3;
			return_from_irq_instr_exec <= return_from_irq_instr_go;
			if (entry_jump)
				pc_q <= pc_vector;
			else if (cyc_en)
				pc_q <= pc_q + 14'h0001;
		end
	end
	assign carry_status = pc_q[1:0];
endmodule
`default_nettype wire

// ===== test/test_sic_irq_ctrl.sv
// self-checking bench for the six-source interrupt control unit
`timescale 1ns/100ps
`default_nettype none

module test_sic_irq_ctrl;
	logic clk = 0, rst = 1, slow = 1, go = 0, rd_s = 0, we = 0;
	logic e0_n = 1, e1_n = 1, oa = 0, ob = 0, oc = 0, sd = 0, sa = 0;
	logic [9:0] addr = 0, sp_x = 10'h3FF;
	logic [3:0] ben = 0, wd = 0, d;
	wire cyc, return_from_irq_instr, ie, irq, fin, push, jump, hit, tbe;
	wire [1:0] cs;
	wire [13:0] pcr, vec;
	wire [9:0] sp;
	wire [15:0] pd;
	wire [3:0] rdat;
	int miscompares = 0, n_compared = 0, n_ev = 0, i;
	logic [3:0] rv [6] = '{4'h8, 4'hA, 4'hA, 4'h2, 4'h0, 4'h0};
	logic [3:0] pv [4] = '{4'hC, 4'hF, 4'hF, 4'h3};
	logic [9:0] fa [6] = '{0, 1, 1, 2, 2, 3};
	logic [3:0] fb [6] = '{4'h4, 4'h1, 4'h4, 4'h1, 4'h4, 4'h1};

	always #5 clk = ~clk;
	always @(posedge clk) if (tbe === 1'b1) n_ev++;

	sic_irq_ctrl sic_irq_ctrl_inst (
		.SYS_CLK(clk), .RESET(rst), .CYC_EN(cyc), .EXT0_PIN_N(e0_n),
		.EXT1_PIN_N(e1_n), .TMRA_OVF(oa), .TMRB_OVF(ob), .TMRC_OVF(oc),
		.SER_DONE(sd), .SER_ABORT(sa), .RETURN_FROM_IRQ_INSTR_EXEC(return_from_irq_instr), .MEM_RD(rd_s),
		.MEM_WE(we), .MEM_ADDR(addr), .MEM_BEN(ben), .MEM_WDATA(wd),
		.CARRY_STATUS(cs), .PC_RETURN(pcr), .MEM_RDATA(rdat),
		.MEM_HIT(hit), .GLOBAL_IE(ie), .IRQ_REQUEST(irq),
		.ENTRY_FINISH(fin), .ENTRY_PUSH_HI(push), .ENTRY_JUMP(jump),
		.PC_VECTOR(vec), .STACK_PTR(sp), .PUSH_DATA(pd), .TMRB_EVENT(tbe));
	sic_core_model sic_core_model_inst (.SYS_CLK(clk), .RESET(rst),
		.slow(slow), .return_from_irq_instr_go(go), .entry_jump(jump), .pc_vector(vec),
		.cyc_en(cyc), .return_from_irq_instr_exec(return_from_irq_instr), .carry_status(cs), .pc_q(pcr));
	////////////////
	task final_report;
		if (miscompares == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task cmp(input string n, input logic [15:0] x, input logic [15:0] g);
		n_compared++;
		if (g !== x) begin
			miscompares++;
			$display("mismatch %s expected %h seen %h", n, x, g);
		end
	endtask
	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task wr(input logic [9:0] a, input logic [3:0] b, input logic [3:0] v);
		@(negedge clk);
		we = 1;
		addr = a;
		ben = b;
		wd = v;
		@(negedge clk);
		we = 0;
	endtask
	task rdn(input logic [9:0] a);
		@(negedge clk);
		rd_s = 1;
		addr = a;
		@(negedge clk);
		rd_s = 0;
		d = rdat;
	endtask
	task rd(input logic [9:0] a, input logic [3:0] x);
		rdn(a);
		cmp("rdata", x, d);
		cmp("hit", a <= 10'h004, hit);
	endtask
	task rtn;
		go <= 1;
		tick(1);
		go <= 0;
		tick(1);
		sp_x = sp_x + 10'h004;
		cmp("ie", 1, ie);
		cmp("sp", sp_x, sp);
	endtask
	task entry(input logic [13:0] v);
		int k;
		for (k = 0; k < 200 && fin !== 1'b1; k++)
			@(negedge clk);
		cmp("finish", 1, fin);
		cmp("vector", v, vec);
		cmp("push_data", {cs, pcr}, pd);
		for (k = 0; k < 200 && {fin, push} !== 2'b00; k++)
			@(negedge clk);
		sp_x = sp_x - 10'h004;
		cmp("sp", sp_x, sp);
		cmp("ie", 0, ie);
		cmp("pc", v, pcr);
	endtask
	////////////////
	initial begin
		#100000;
		miscompares++;
		final_report;
	end
	initial begin
		tick(20);
		rst = 0;
		cmp("sp", 10'h3FF, sp);
		cmp("vector", 0, vec);
		for (i = 0; i < 6; i++)
			rd(i, rv[i]);
		wr(1, 4'hF, 4'h5);
		rd(1, 4'h0);
		wr(1, 4'hA, 4'hA);
		wr(5, 4'hF, 4'hF);
		rd(5, 4'h0);
		e1_n = 0;
		tick(1);
		e1_n = 1;
		tick(40);
		cmp("tmrb_event", 0, n_ev);
		e0_n = 0;
		e1_n = 0;
		tick(40);
		cmp("tmrb_event", 1, n_ev);
		rd(0, 4'h8);
		rd(1, 4'hA);
		e0_n = 1;
		e1_n = 1;
		tick(40);
		wr(4, 4'h3, 4'h3);
		rd(4, 4'h3);
		e0_n = 0;
		e1_n = 0;
		tick(40);
		cmp("tmrb_event", 1, n_ev);
		{oa, ob, oc, sd} = 4'hF;
		tick(1);
		{oa, ob, oc, sd} = 4'h0;
		for (i = 0; i < 4; i++)
			rd(i, pv[i]);
		cmp("irq", 0, irq);
		wr(0, 4'h1, 4'h1);
		tick(10);
		cmp("finish", 0, fin);
		wr(0, 4'h1, 4'h0);
		for (i = 0; i < 4; i++)
			wr(i, rv[i], 4'h0);
		tick(2);
		cmp("irq", 1, irq);
		cmp("finish", 0, fin);
		for (i = 0; i < 6; i++) begin
			slow = i[0];
			if (i == 0)
				wr(0, 4'h1, 4'h1);
			else
				rtn();
			entry(2 * i + 2);
			rdn(fa[i]);
			cmp("pending", fb[i], d & fb[i]);
			wr(fa[i], fb[i], 4'h0);
		end
		rtn();
		tick(5);
		cmp("finish", 0, fin);
		sa = 1;
		tick(1);
		sa = 0;
		entry(14'h000C);
		wr(3, 4'h1, 4'h0);
		@(negedge clk);
		{we, addr, ben, wd, oa} = {1'b1, 10'h001, 4'h4, 4'h0, 1'b1};
		@(negedge clk);
		{we, oa} = 2'b00;
		rd(1, 4'h4);
		rst = 1;
		tick(3);
		rst = 0;
		sp_x = 10'h3FF;
		cmp("sp", sp_x, sp);
		rd(0, 4'h8);
		final_report;
	end
endmodule
`default_nettype wire
